// ===== core/cfsr_receiver.sv
// Character framing and synchronisation logic of a serial tape receiver.
// Assumes serial data and a bit clock from line equipment (asynchronous
// pins), operator buttons on pins, and an APB master on the core clock.
`timescale 1ns/1ps

module cfsr_receiver
  import cfsr_pkg::*;
#(
  parameter int DLY_CYCLES = CHAR_DLY_CYC  // Delayed shift, in core cycles
) (
  input wire logic clock,             // 200 MHz core clock
  input wire logic rst_b,             // Synchronous reset, active low
  input wire logic psel,              // APB select
  input wire logic penable,           // APB enable
  input wire logic pwrite,            // APB write
  input wire logic [7:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,     // APB write data
  output logic [31:0] prdata,         // APB read data
  output logic pready,                // APB ready
  output logic pslverr,               // APB error on unmapped address
  input wire logic line_data,         // Serial data pin, high is marking
  input wire logic line_clk,          // Bit clock pin, rises at transitions
  input wire logic [7:0] char_levels, // Shift register levels 1..8, high marking
  input wire logic method_btn,        // Method control button pin
  input wire logic slip_btn,          // Manual slip button pin
  output logic char_shift,            // Character shift pulse
  output logic char_shift_dly,        // Delayed character shift pulse
  output logic in_sync,               // Aligned to character boundaries
  output logic auto_ind,              // Automatic mode indicator
  output logic manual_ind             // Manual mode indicator
);

  // ------------------------------------------------------------
  // Local types and helpers
  // ------------------------------------------------------------
  localparam int DW = $clog2(DLY_CYCLES + 1);   // Delay timer width

  // Delay timer states
  typedef enum logic [1:0] {
    CFSR_DLY_IDLE = 2'b01,   // No delayed shift pending
    CFSR_DLY_RUN = 2'b10     // Counting down to delayed shift
  } cfsr_dly_e;

  // Pulses counted so far: distance of stage code below start code
  function automatic logic [3:0] pulses_done(input logic [3:0] start,
                                             input logic [3:0] stage);
    pulses_done = start - stage;
  endfunction

  // Idle character: levels 2..6 marking, plus the used ones of 1, 7, 8
  function automatic logic idle_match(input logic [7:0] lv,
                                      input logic [1:0] sel);
    logic need1;
    logic need7;
    logic need8;
    need1 = (sel != LVL_5);
    need7 = (sel == LVL_7) || (sel == LVL_8);
    need8 = (sel == LVL_8);
    idle_match = (&lv[5:1]) && (lv[0] || !need1) &&
                 (lv[6] || !need7) && (lv[7] || !need8);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic clk_rise;      // Bit clock pulse, one core cycle
  logic data_fall;     // Marking to spacing transition
  logic meth_press;    // Method control press
  logic slip_press;    // Manual slip press

  // Bit clock edges
  cfsr_sync_edge u_clk_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(line_clk),
    .level(),
    .rise(clk_rise),
    .fall()
  );

  // Serial data edges
  cfsr_sync_edge u_data_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(line_data),
    .level(),
    .rise(),
    .fall(data_fall)
  );

  // Method button, one pulse per press
  cfsr_sync_edge u_meth_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(method_btn),
    .level(),
    .rise(meth_press),
    .fall()
  );

  // Slip button, one pulse per press
  cfsr_sync_edge u_slip_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(slip_btn),
    .level(),
    .rise(slip_press),
    .fall()
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [3:0] units_q;        // Units per character setting
  logic ss_q;                 // Start-stop framing
  logic free_q;               // Free stop length option
  logic [1:0] lvl_q;          // Code level selection
  logic [3:0] stage_q;        // Four counter stages
  logic gate1_q;              // First character gate flop
  logic gate2_q;              // Second character gate flop
  logic method_q;             // High for automatic alignment
  logic search_q;             // Automatic search running
  logic slip_req_q;           // Slip request armed
  logic slip_q;               // Blocks the next bit clock
  logic in_sync_q;            // Aligned flag
  logic shift_q;              // Character shift pulse
  logic shift_dly_q;          // Delayed character shift pulse
  logic auto_ind_q;           // Automatic indicator drive
  logic manual_ind_q;         // Manual indicator drive
  logic [15:0] chars_q;       // Characters shifted, wraps
  cfsr_dly_e dly_st_q;        // Delay timer state
  logic [DW-1:0] dly_cnt_q;   // Delay timer count
  logic [31:0] prdata_q;      // Read data register
  logic pready_q;             // Ready register
  logic pslverr_q;            // Error register

  // ------------------------------------------------------------
  // Counter clock gating
  // ------------------------------------------------------------
  logic [3:0] start_code;     // Counter start state for the framing
  logic gate_open;            // Character gate passes clocks
  logic cnt_tick;             // Bit clock reaching the counter
  logic char_done;            // This tick completes a character
  logic [3:0] next_pulse;     // Pulse number after this tick

  assign start_code = ss_q ? CNT_START_SS : CNT_START_SYN;
  assign gate_open = !free_q || gate1_q;
  assign cnt_tick = clk_rise && gate_open && !slip_q;
  assign next_pulse = pulses_done(start_code, stage_q) + 4'h1;
  assign char_done = cnt_tick && (next_pulse == units_q);

  // ------------------------------------------------------------
  // Units counter
  // ------------------------------------------------------------
  // Counts gated bit clocks; returns to pulse zero with the shift
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage_q <= CNT_START_SYN;
    end else if (char_done) begin
      stage_q <= start_code;
    end else if (cnt_tick) begin
      stage_q <= stage_q - 4'h1;
    end else if (!gate_open) begin
      stage_q <= start_code;
    end
  end

  // Character shift pulse and character count
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shift_q <= 1'b0;
      chars_q <= 16'h0000;
    end else begin
      shift_q <= char_done;
      if (char_done) begin
        chars_q <= chars_q + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Delayed character shift timer
  // ------------------------------------------------------------
  // Starts at the shift and emits one pulse after the fixed delay
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dly_st_q <= CFSR_DLY_IDLE;
      dly_cnt_q <= '0;
      shift_dly_q <= 1'b0;
    end else begin
      shift_dly_q <= 1'b0;
      case (dly_st_q)
        CFSR_DLY_IDLE: begin
          if (shift_q) begin
            dly_cnt_q <= DW'(DLY_CYCLES - 1);
            dly_st_q <= CFSR_DLY_RUN;
          end
        end
        CFSR_DLY_RUN: begin
          if (dly_cnt_q == '0) begin
            shift_dly_q <= 1'b1;
            dly_st_q <= CFSR_DLY_IDLE;
          end else begin
            dly_cnt_q <= dly_cnt_q - DW'(1);
          end
        end
        default: begin
          dly_st_q <= CFSR_DLY_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Character gate for free stop length
  // ------------------------------------------------------------
  // Closes after each character, reopens on the next start unit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      gate1_q <= 1'b1;
      gate2_q <= 1'b1;
    end else if (!free_q) begin
      // Fixed length characters keep the gate open
      gate1_q <= 1'b1;
      gate2_q <= 1'b1;
    end else begin
      if (shift_dly_q) begin
        gate1_q <= 1'b0;
      end else if (data_fall && !gate1_q && !gate2_q) begin
        gate1_q <= 1'b1;
      end
      if (clk_rise && gate1_q) begin
        gate2_q <= 1'b1;
      end else if (clk_rise && !gate1_q) begin
        gate2_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Method and search control
  // ------------------------------------------------------------
  // A press in automatic mode on idle data, out of sync and not searching, starts a search; any other
  // press toggles the method and abandons a running search
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      method_q <= 1'b0;
      search_q <= 1'b0;
    end else if (meth_press) begin
      if (method_q && !search_q && !in_sync_q &&
          idle_match(char_levels, lvl_q)) begin
        search_q <= 1'b1;
      end else begin
        method_q <= !method_q;
        search_q <= 1'b0;
      end
    end else if (shift_q && in_sync_q) begin
      search_q <= 1'b0;
    end
  end

  // Mode indicator drives
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      auto_ind_q <= 1'b0;
      manual_ind_q <= 1'b1;
    end else begin
      auto_ind_q <= method_q;
      manual_ind_q <= !method_q;
    end
  end

  // ------------------------------------------------------------
  // Alignment detection
  // ------------------------------------------------------------
  // Sampled as the character moves into storage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      in_sync_q <= 1'b0;
    end else if (char_done) begin
      in_sync_q <= idle_match(char_levels, lvl_q);
    end
  end

  // ------------------------------------------------------------
  // Clock slipping
  // ------------------------------------------------------------
  // Request armed by the delayed shift while searching, or by a manual
  // press; set wins over the clear of the same cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      slip_req_q <= 1'b0;
    end else if (shift_dly_q && search_q) begin
      slip_req_q <= 1'b1;
    end else if (slip_press && !method_q) begin
      slip_req_q <= 1'b1;
    end else if (clk_rise && slip_q) begin
      slip_req_q <= 1'b0;
    end
  end

  // Slip flop: set by one bit clock, swallows the next and clears
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      slip_q <= 1'b0;
    end else if (clk_rise) begin
      if (slip_q) begin
        slip_q <= 1'b0;
      end else if (slip_req_q && gate_open) begin
        slip_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic setup_ph;     // Setup cycle of a transfer
  logic access_done;  // Access cycle completing this edge
  logic hit_ctrl;     // Control register addressed
  logic hit_stat;     // Status register addressed
  logic hit_chrs;     // Count register addressed

  assign setup_ph = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign hit_ctrl = (paddr == CFSR_CTRL_OFS);
  assign hit_stat = (paddr == CFSR_STAT_OFS);
  assign hit_chrs = (paddr == CFSR_CHRS_OFS);

  // Ready, error and read data are prepared in the setup cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready_q <= 1'b1;
      pslverr_q <= !(hit_ctrl || hit_stat || hit_chrs);
      if (pwrite || !(hit_ctrl || hit_stat || hit_chrs)) begin
        prdata_q <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata_q <= {24'h000000, lvl_q, free_q, ss_q, units_q};
      end else if (hit_stat) begin
        prdata_q <= {21'h000000, gate2_q, gate1_q, slip_q, slip_req_q,
                     search_q, method_q, in_sync_q, stage_q};
      end else begin
        prdata_q <= {16'h0000, chars_q};
      end
    end else if (access_done) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Control register write at the completing edge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      units_q <= CTL_UNITS_RST;
      ss_q <= 1'b0;
      free_q <= 1'b0;
      lvl_q <= CTL_LVL_RST;
    end else if (access_done && pwrite && hit_ctrl) begin
      units_q <= pwdata[CTL_UNITS_LSB +: 4];
      ss_q <= pwdata[CTL_SS_BIT];
      free_q <= pwdata[CTL_FREE_BIT];
      lvl_q <= pwdata[CTL_LVL_LSB +: 2];
    end
  end

  // ------------------------------------------------------------
  // Outputs, all from flops
  // ------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign char_shift = shift_q;
  assign char_shift_dly = shift_dly_q;
  assign in_sync = in_sync_q;
  assign auto_ind = auto_ind_q;
  assign manual_ind = manual_ind_q;

endmodule // cfsr_receiver

// ===== inc/cfsr_pkg.sv
// Package for the character framing and sync receiver: register map,
// field positions, reset values and timing constants.
// Assumes a 200 MHz core clock and a 32-bit APB register bus.
package cfsr_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;                       // Core clock rate
  localparam int CHAR_DLY_NS = 100000;                // Delayed shift, 100 us
  localparam int CHAR_DLY_CYC = CHAR_DLY_NS * CLK_MHZ / 1000; // Cycles of delay

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CFSR_CTRL_OFS = 8'h00;       // Control, read/write
  localparam logic [7:0] CFSR_STAT_OFS = 8'h04;       // Status, read only
  localparam logic [7:0] CFSR_CHRS_OFS = 8'h08;       // Character count, read only

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int CTL_UNITS_LSB = 0;                   // Units per character, 4 bits
  localparam int CTL_SS_BIT = 4;                      // Start-stop framing
  localparam int CTL_FREE_BIT = 5;                    // Free stop length option
  localparam int CTL_LVL_LSB = 6;                     // Code levels, 2 bits
  localparam logic [3:0] CTL_UNITS_RST = 4'h5;        // Five units after reset
  localparam logic [1:0] CTL_LVL_RST = 2'h0;          // Five levels after reset

  // Code level selections
  localparam logic [1:0] LVL_5 = 2'h0;
  localparam logic [1:0] LVL_6 = 2'h1;
  localparam logic [1:0] LVL_7 = 2'h2;
  localparam logic [1:0] LVL_8 = 2'h3;

  // ------------------------------------------------------------
  // Counter start states (four stages)
  // ------------------------------------------------------------
  localparam logic [3:0] CNT_START_SYN = 4'he;        // First stage clear
  localparam logic [3:0] CNT_START_SS = 4'hf;         // All stages set

endpackage

// ===== core/cfsr_sync_edge.sv
// Two-stage synchroniser with edge pulses for one asynchronous input.
// Assumes the input comes from a pin outside the core clock domain.
`timescale 1ns/1ps
module cfsr_sync_edge (
  input wire logic clock,     // Core clock
  input wire logic rst_b,     // Synchronous reset, active low
  input wire logic async_in,  // Asynchronous input level
  output logic level,         // Synchronised level
  output logic rise,          // One-cycle pulse on a rising edge
  output logic fall           // One-cycle pulse on a falling edge
);

  logic meta_q;               // First stage, read only by the second
  logic sync_q;               // Second stage
  logic last_q;               // Previous synchronised value

  // ------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses come from the settled stages only
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule // cfsr_sync_edge

// ===== dv/cfsr_line_model.sv
// Line equipment model: free-running bit clock and serial data.
// Assumes the bench loads a frame pattern and its length in units.
`timescale 1ns/1ps
module cfsr_line_model (
  input wire logic [15:0] frame, // Frame bits, first sent in bit 0
  input wire logic [4:0] len,    // Frame length in units
  output logic line_clk,         // Bit clock, 48 ns period
  output logic line_data         // Serial data, high is marking
);
  int idx; // Next bit of the frame
  // Clock runs without pause; data moves on each rising edge
  initial begin
    line_clk = 1'b0;
    line_data = 1'b1;
    idx = 0;
    #7;
    forever begin
      #24 line_clk = 1'b1;
      line_data = frame[idx];
      idx = (idx + 1 >= int'(len)) ? 0 : idx + 1;
      #24 line_clk = 1'b0;
    end
  end
endmodule // cfsr_line_model

// ===== dv/cfsr_receiver_chk.sv
// Port checker for the receiver, bound to its top module.
// Assumes one core clock domain and synchronous active-low reset.
`timescale 1ns/1ps
module cfsr_receiver_chk #(
  parameter int DLY_CYCLES = 20 // Delayed shift, in core cycles
) (
  input wire logic clock,          // Core clock
  input wire logic rst_b,          // Reset, active low
  input wire logic psel,           // APB select
  input wire logic penable,        // APB enable
  input wire logic [7:0] paddr,    // APB address
  input wire logic pready,         // APB ready
  input wire logic pslverr,        // APB error
  input wire logic line_clk,       // Bit clock pin
  input wire logic char_shift,     // Character shift
  input wire logic char_shift_dly, // Delayed shift
  input wire logic in_sync,        // Aligned flag
  input wire logic auto_ind,       // Automatic mode lamp
  input wire logic manual_ind      // Manual mode lamp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic lc_q; // Sampled bit clock
  logic [3:0] since_q; // Cycles since a bit clock rise
  // Age of the last bit clock rise, saturating
  always_ff @(posedge clock) begin
    lc_q <= line_clk;
    if (!rst_b) since_q <= 4'hf;
    else if (line_clk && !lc_q) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  a_shift_single: assert property (char_shift |=> !char_shift)
    else $error("shift pulse too long");
  a_shift_after_clk: assert property (char_shift |-> since_q inside {[1:7]})
    else $error("shift without bit clock");
  a_dly_after: assert property (char_shift_dly |-> $past(char_shift, DLY_CYCLES + 1))
    else $error("delayed shift misplaced");
  a_dly_single: assert property (char_shift_dly |=> !char_shift_dly)
    else $error("delayed shift too long");
  a_mode_excl: assert property (manual_ind == !auto_ind)
    else $error("mode lamps disagree");
  a_sync_at_shift: assert property ($changed(in_sync) |-> $rose(char_shift))
    else $error("in-sync moved off shift");
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_unmapped: assert property (pready && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr)
    else $error("no error on unmapped");
endmodule // cfsr_receiver_chk

bind cfsr_receiver cfsr_receiver_chk #(.DLY_CYCLES(DLY_CYCLES)) chk_u (.clock, .rst_b, .psel,
  .penable, .paddr, .pready, .pslverr, .line_clk, .char_shift, .char_shift_dly, .in_sync,
  .auto_ind, .manual_ind);

// ===== dv/cfsr_receiver_test.sv
// Self-checking bench for the receiver with a line equipment model.
// Assumes the checker is bound and the delayed shift is 3 cycles, well
// inside one bit period, so the gate closes before the next bit clock.
`timescale 1ns/1ps
module cfsr_receiver_test import cfsr_pkg::*; ;
  typedef struct {logic [7:0] ctrl; logic [15:0] frame; logic [4:0] len; logic [7:0] lvls;
    logic [4:0] gap; logic [3:0] stage; logic sync;} cfsr_row_s;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, perr, lc_q;
  logic [7:0] paddr, char_levels;
  logic [31:0] pwdata, prdata, rd;
  logic line_data, line_clk, method_btn, slip_btn;
  logic char_shift, char_shift_dly, in_sync, auto_ind, manual_ind;
  logic [15:0] frame;
  logic [4:0] len, run_n, gap_n;
  int n_errors = 0, check_count = 0, cyc_n = 0;
  int slip_sum; // Bit clocks over a full round of manual slips
  // Control, frame, length, levels, units between shifts, start stage, in-sync
  cfsr_row_s rows [0:4] = '{'{8'h05, 16'hffff, 5'd16, 8'h3e, 5'd5, 4'he, 1'b1},
    '{8'h97, 16'hffff, 5'd16, 8'h3f, 5'd7, 4'hf, 1'b0},
    '{8'hca, 16'hffff, 5'd16, 8'hff, 5'd10, 4'he, 1'b1},
    '{8'h56, 16'hffff, 5'd16, 8'h3e, 5'd6, 4'hf, 1'b0},
    '{8'h36, 16'h01da, 5'd9, 8'h3e, 5'd9, 4'hf, 1'b1}};
  cfsr_receiver #(.DLY_CYCLES(3)) dut_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .line_data, .line_clk, .char_levels, .method_btn,
    .slip_btn, .char_shift, .char_shift_dly, .in_sync, .auto_ind, .manual_ind);
  cfsr_line_model line_u (.frame, .len, .line_clk, .line_data);
  // ----
  // Clock, timeout and bit clocks between character shifts
  // ----
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_errors++;
      tally_and_finish;
    end
    lc_q <= line_clk;
    if (char_shift === 1'b1) begin
      gap_n <= run_n;
      run_n <= 5'(line_clk && !lc_q);
    end else if (line_clk && !lc_q) run_n <= run_n + 5'd1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for a shift; gap_n then holds the bit clocks since the last one
  task automatic wait_shift;
    do @(posedge clock); while (char_shift !== 1'b1);
    @(posedge clock);
  endtask
  task automatic press(input logic slip);
    @(posedge clock);
    if (slip) slip_btn <= 1'b1;
    else method_btn <= 1'b1;
    repeat (6) @(posedge clock);
    slip_btn <= 1'b0;
    method_btn <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    {clock, rst_b, psel, penable, pwrite, paddr, pwdata, method_btn, slip_btn} = '0;
    {char_levels, run_n, gap_n, lc_q} = '0;
    frame = 16'hffff;
    len = 5'd16;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    check(32'(manual_ind), 32'h1);
    apb(1'b0, CFSR_CTRL_OFS, 32'h0);
    check(rd, 32'h5);
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], perr}, 32'h1);
    foreach (rows[i]) begin
      apb(1'b1, CFSR_CTRL_OFS, 32'(rows[i].ctrl));
      frame <= rows[i].frame;
      len <= rows[i].len;
      char_levels <= rows[i].lvls;
      repeat (3) wait_shift;
      check(32'(gap_n), 32'(rows[i].gap));
      check(32'(in_sync), 32'(rows[i].sync));
      apb(1'b0, CFSR_STAT_OFS, 32'h0);
      check(32'(rd[3:0]), 32'(rows[i].stage));
    end
    apb(1'b1, CFSR_CTRL_OFS, 32'h5);
    char_levels <= 8'h00;
    repeat (2) wait_shift;
    // As many slips as units per character bring the counter back round
    slip_sum = 0;
    repeat (5) begin
      press(1'b1);
      wait_shift;
      check(32'(gap_n), 32'd6);
      slip_sum += int'(gap_n);
    end
    check(32'(slip_sum % 5), 32'h0);
    press(1'b0);
    check(32'({auto_ind, manual_ind}), 32'h2);
    wait_shift;
    char_levels <= 8'h3e;
    press(1'b0);
    char_levels <= 8'h00;
    apb(1'b0, CFSR_STAT_OFS, 32'h0);
    check(32'(rd[6]), 32'h1);
    // No slip until the first delayed shift after the search starts
    wait_shift;
    check(32'(gap_n), 32'd5);
    repeat (2) begin
      wait_shift;
      check(32'(gap_n), 32'd6);
    end
    char_levels <= 8'h3e;
    wait_shift;
    check(32'(in_sync), 32'h1);
    wait_shift;
    check(32'(gap_n), 32'd5);
    press(1'b0);
    check(32'({auto_ind, in_sync}), 32'h1);
    apb(1'b1, CFSR_CTRL_OFS, 32'h36);
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    apb(1'b0, CFSR_CTRL_OFS, 32'h0);
    check(rd, 32'h5);
    check(32'({auto_ind, manual_ind, in_sync}), 32'h2);
    tally_and_finish;
  end
endmodule // cfsr_receiver_test
